//--- verilog/i2ctx_feed.sv
`default_nettype none

// transmit data path of a two-wire controller: queue, serialiser, flags, dma
module i2ctx_feed
  import i2ctx_pkg::*;
(
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic irq_o,
  output i2ctx_dma_s dma_req_o
);
  i2ctx_bus_s req; // bundled bus request
  logic [1:0] scl_sy_reg, sda_sy_reg; // two-stage pin synchronisers
  logic scl_q_reg, sda_q_reg; // previous synchronised levels
  logic scl_s, sda_s; // synchronised pin levels
  logic scl_rise, scl_fall, start_det, stop_det; // bus events
  i2ctx_state_e state_reg, state_next; // engine state
  logic [2:0] bit_reg, bit_next; // bit index in byte
  logic [7:0] sh_reg, sh_next; // shift register
  logic sda_drv_reg, sda_drv_next; // pull data line low
  logic scl_drv_reg, scl_drv_next; // pull clock line low
  logic flag_reg, flag_next; // per-state helper flag
  logic [1:0] ph_reg, ph_next; // master bit phase
  logic [2:0] div_reg, div_next; // master phase divider
  logic tick; // master phase strobe
  logic [1:0] op_reg, op_next; // last operation
  logic [1:0] st_reg, st_next; // last operation status
  logic pop, flush, ev_req, ev_empty, ev_done, ev_nack, go_clr; // engine strobes
  logic slave_any, slave_rd; // slave activity decode
  logic [7:0] addr_byte; // address byte being completed
  logic wait_reg, wait_next; // waitrequest
  logic [31:0] rdata_reg, rdata_next; // read data
  logic acc; // request accepted this edge
  logic go_reg, go_next; // master write requested
  logic [6:0] own_reg, own_next; // own slave address
  logic [3:0] thr_reg, thr_next; // nearly-empty threshold
  logic dma_en_reg, dma_en_next; // dma mode
  logic [1:0] dsz_reg, dsz_next; // dma burst size code
  logic [IRQ_W-2:0] raw_reg, raw_next; // sticky flags
  logic [IRQ_W-1:0] mask_reg, mask_next; // interrupt mask
  logic [IRQ_W-1:0] flags; // sticky flags plus live nearly-empty
  logic irq_reg, irq_next; // interrupt output
  i2ctx_dma_s dma_reg, dma_next; // dma request outputs
  logic pin_lo_reg; // constant low level for open-drain pins
  logic push; // queue push
  logic [7:0] head; // queue head byte
  logic [LVL_W-1:0] level, free; // queue fill and free room
  logic empty; // queue empty
  logic near; // nearly-empty condition

  assign req = '{rd: avs_read_i, wr: avs_write_i, addr: avs_address_i,
                 be: avs_byteenable_i, wdata: avs_writedata_i};

  // transmit queue
  i2ctx_fifo u_fifo (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .push_i(push),
    .data_i(req.wdata[7:0]),
    .pop_i(pop),
    .flush_i(flush),
    .head_o(head),
    .level_o(level),
    .empty_o(empty)
  );

  // pin synchronisers; the first stage feeds only the second
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      scl_sy_reg <= 2'h3;
      sda_sy_reg <= 2'h3;
      scl_q_reg <= 1'h1;
      sda_q_reg <= 1'h1;
      pin_lo_reg <= 1'h0;
    end else begin
      scl_sy_reg <= {scl_sy_reg[0], scl_i};
      sda_sy_reg <= {sda_sy_reg[0], sda_i};
      scl_q_reg <= scl_sy_reg[1];
      sda_q_reg <= sda_sy_reg[1];
      pin_lo_reg <= 1'h0;
    end
  end

  // edge and start/stop detection on synchronised levels
  always_comb begin
    scl_s = scl_sy_reg[1];
    sda_s = sda_sy_reg[1];
    scl_rise = scl_s && !scl_q_reg;
    scl_fall = !scl_s && scl_q_reg;
    start_det = scl_s && scl_q_reg && !sda_s && sda_q_reg;
    stop_det = scl_s && scl_q_reg && sda_s && !sda_q_reg;
    tick = (div_reg == 3'(PHASE_CYC - 1));
    slave_any = (state_reg == ST_SADDR) || (state_reg == ST_SAACK) ||
                (state_reg == ST_SLOAD) || (state_reg == ST_SBIT) || (state_reg == ST_MACK && op_reg == OP_RFS);
    slave_rd = slave_any && (state_reg != ST_SADDR);
    addr_byte = {sh_reg[6:0], sda_s};
  end

  // engine next state: master write and slave read share one shifter
  always_comb begin
    state_next = state_reg;
    bit_next = bit_reg;
    sh_next = sh_reg;
    sda_drv_next = sda_drv_reg;
    scl_drv_next = scl_drv_reg;
    flag_next = flag_reg;
    ph_next = ph_reg;
    div_next = tick ? 3'h0 : div_reg + 3'h1;
    op_next = op_reg;
    st_next = st_reg;
    pop = 1'h0;
    flush = 1'h0;
    ev_req = 1'h0;
    ev_empty = 1'h0;
    ev_done = 1'h0;
    ev_nack = 1'h0;
    go_clr = 1'h0;
    unique case (state_reg)
      ST_IDLE: begin
        sda_drv_next = 1'h0;
        scl_drv_next = 1'h0;
        // start only once a byte is queued
        if (go_reg && !empty) begin
          state_next = ST_MSTART;
          op_next = OP_MW;
          st_next = ST_ON;
          go_clr = 1'h1;
          div_next = 3'h0;
          ph_next = 2'h0;
        end else if (start_det) begin
          state_next = ST_SADDR;
          bit_next = 3'h0;
        end
      end
      ST_MSTART: begin
        // start condition: data low while clock high, then clock low
        if (tick) begin
          if (ph_reg == 2'h0) begin
            sda_drv_next = 1'h1;
            ph_next = 2'h1;
          end else begin
            scl_drv_next = 1'h1;
            pop = 1'h1;
            sh_next = head;
            bit_next = 3'h0;
            ph_next = 2'h0;
            state_next = ST_MBIT;
          end
        end
      end
      ST_MBIT: begin
        // phase 0 sets data, 1 releases clock, 2 pulls it low again
        if (tick) begin
          if (ph_reg == 2'h0) begin
            sda_drv_next = ~sh_reg[0];
            ph_next = 2'h1;
          end else if (ph_reg == 2'h1) begin
            scl_drv_next = 1'h0;
            ph_next = 2'h2;
          end else if (scl_s) begin
            // a stretching slave holds the clock, so wait for it high
            scl_drv_next = 1'h1;
            sh_next = {1'h0, sh_reg[7:1]};
            bit_next = bit_reg + 3'h1;
            ph_next = 2'h0;
            if (bit_reg == 3'h7) begin
              state_next = ST_MACK;
            end
          end
        end
      end
      ST_MACK: begin
        // master write acknowledge slot; nack or empty queue ends the write
        if (tick) begin
          if (ph_reg == 2'h0) begin
            sda_drv_next = 1'h0;
            ph_next = 2'h1;
          end else if (ph_reg == 2'h1) begin
            scl_drv_next = 1'h0;
            ph_next = 2'h2;
          end else if (scl_s) begin
            scl_drv_next = 1'h1;
            ph_next = 2'h0;
            if (sda_s || empty) begin
              st_next = sda_s ? ST_ABORT : ST_OK;
              state_next = ST_MSTOP;
            end else begin
              pop = 1'h1;
              sh_next = head;
              state_next = ST_MBIT;
            end
          end
        end
      end
      ST_MSTOP: begin
        // stop condition: data low, clock released, then data released
        if (tick) begin
          if (ph_reg == 2'h0) begin
            sda_drv_next = 1'h1;
            ph_next = 2'h1;
          end else if (ph_reg == 2'h1) begin
            scl_drv_next = 1'h0;
            ph_next = 2'h2;
          end else begin
            sda_drv_next = 1'h0;
            ph_next = 2'h0;
            state_next = ST_IDLE;
          end
        end
      end
      ST_SADDR: begin
        // address byte arrives most significant bit first
        if (scl_rise) begin
          sh_next = addr_byte;
          bit_next = bit_reg + 3'h1;
          if (bit_reg == 3'h7) begin
            if (addr_byte[7:1] == own_reg && addr_byte[0]) begin
              flush = 1'h1;
              ev_req = 1'h1;
              op_next = OP_RFS;
              st_next = ST_ON;
              flag_next = 1'h0;
              state_next = ST_SAACK;
            end else begin
              state_next = ST_IDLE;
            end
          end
        end
      end
      ST_SAACK: begin
        // drive the address acknowledge for one clock
        if (scl_fall) begin
          sda_drv_next = !flag_reg;
          flag_next = !flag_reg;
          if (flag_reg) begin
            flag_next = 1'h0;
            state_next = ST_SLOAD;
          end
        end
      end
      ST_SLOAD: begin
        // clock is low here; hold it low until a byte is queued
        if (empty) begin
          scl_drv_next = 1'h1;
          if (!flag_reg) begin
            ev_empty = 1'h1;
            flag_next = 1'h1;
          end
        end else begin
          pop = 1'h1;
          sh_next = head;
          sda_drv_next = ~head[0];
          scl_drv_next = 1'h0;
          bit_next = 3'h0;
          state_next = ST_SBIT;
        end
      end
      ST_SBIT: begin
        // next bit on each falling clock, least significant first
        if (scl_fall) begin
          if (bit_reg == 3'h7) begin
            sda_drv_next = 1'h0;
            flag_next = 1'h0;
            state_next = ST_MACK;
          end else begin
            sh_next = {1'h0, sh_reg[7:1]};
            sda_drv_next = ~sh_reg[1];
            bit_next = bit_reg + 3'h1;
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // slave read reuses the acknowledge state, sampling the master's answer
    if (state_reg == ST_MACK && op_reg == OP_RFS) begin
      div_next = 3'h0;
      ph_next = 2'h0;
      pop = 1'h0;
      st_next = st_reg;
      state_next = ST_MACK;
      scl_drv_next = 1'h0;
      sda_drv_next = 1'h0;
      if (scl_rise) begin
        flag_next = sda_s;
      end
      if (scl_fall) begin
        if (flag_reg) begin
          ev_done = 1'h1;
          ev_nack = 1'h1;
          st_next = ST_OK;
          state_next = ST_IDLE;
        end else begin
          flag_next = 1'h0;
          state_next = ST_SLOAD;
        end
      end
    end
    // start or stop inside a slave transfer ends it
    if (slave_any && (start_det || stop_det)) begin
      scl_drv_next = 1'h0;
      sda_drv_next = 1'h0;
      bit_next = 3'h0;
      state_next = start_det ? ST_SADDR : ST_IDLE;
      if (slave_rd) begin
        ev_done = 1'h1;
        st_next = ST_ABORT;
      end
    end
  end

  // engine registers
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= ST_IDLE;
      bit_reg <= 3'h0;
      sh_reg <= 8'h00;
      sda_drv_reg <= 1'h0;
      scl_drv_reg <= 1'h0;
      flag_reg <= 1'h0;
      ph_reg <= 2'h0;
      div_reg <= 3'h0;
      op_reg <= OP_MW;
      st_reg <= ST_NOP;
    end else begin
      state_reg <= state_next;
      bit_reg <= bit_next;
      sh_reg <= sh_next;
      sda_drv_reg <= sda_drv_next;
      scl_drv_reg <= scl_drv_next;
      flag_reg <= flag_next;
      ph_reg <= ph_next;
      div_reg <= div_next;
      op_reg <= op_next;
      st_reg <= st_next;
    end
  end

  // register file, flags, interrupt and dma requests
  always_comb begin
    acc = (req.rd || req.wr) && !wait_reg;
    wait_next = !((req.rd || req.wr) && wait_reg);
    push = acc && req.wr && req.addr == OFF_TFR && req.be[0];
    near = level <= LVL_W'(thr_reg);
    flags = {near, raw_reg};
    free = LVL_W'(FIFO_DEPTH) - level;
    go_next = go_reg && !go_clr;
    own_next = own_reg;
    thr_next = thr_reg;
    dma_en_next = dma_en_reg;
    dsz_next = dsz_reg;
    mask_next = mask_reg;
    raw_next = raw_reg;
    if (acc && req.wr) begin
      unique case (req.addr)
        OFF_CTRL: begin
          if (req.be[0] && req.wdata[CTRL_GO_BIT]) begin
            go_next = 1'h1;
          end
          if (req.be[1]) begin
            own_next = req.wdata[CTRL_ADDR_LSB +: 7];
          end
          if (req.be[2]) begin
            thr_next = req.wdata[CTRL_THR_LSB +: 4];
          end
        end
        OFF_DMA: begin
          if (req.be[0]) begin
            dma_en_next = req.wdata[DMA_EN_BIT];
            dsz_next = req.wdata[DMA_SZ_LSB +: 2];
          end
        end
        OFF_RAW: begin
          if (req.be[0]) begin
            raw_next = raw_reg & ~req.wdata[IRQ_W-2:0];
          end
        end
        OFF_MASK: begin
          if (req.be[0]) begin
            mask_next = req.wdata[IRQ_W-1:0];
          end
        end
        default: begin
          mask_next = mask_reg;
        end
      endcase
    end
    // hardware set wins over a clear in the same cycle
    raw_next[IRQ_REQ] = raw_next[IRQ_REQ] || ev_req;
    raw_next[IRQ_EMPTY] = raw_next[IRQ_EMPTY] || ev_empty;
    raw_next[IRQ_DONE] = raw_next[IRQ_DONE] || ev_done;
    irq_next = |(flags & mask_reg);
    // read data captured while waitrequest is still high
    rdata_next = 32'h0000_0000;
    unique case (req.addr)
      OFF_CTRL: rdata_next = {12'h000, thr_reg, 1'h0, own_reg, 7'h00, go_reg};
      OFF_STATUS: rdata_next = {19'h0_0000, level, 4'h0, st_reg, op_reg};
      OFF_DMA: rdata_next = {29'h0000_0000, dsz_reg, dma_en_reg};
      OFF_RAW: rdata_next = {28'h000_0000, flags};
      OFF_MASK: rdata_next = {28'h000_0000, mask_reg};
      default: rdata_next = 32'h0000_0000;
    endcase
    // dma requests while a master write waits to start or a slave read runs, sized by free room
    dma_next.burst = dma_en_reg && (go_reg || slave_rd) &&
                     free >= i2ctx_burst_len(dsz_reg);
    dma_next.single = dma_en_reg && (go_reg || slave_rd) && free != '0 &&
                      free < i2ctx_burst_len(dsz_reg);
    dma_next.last = dma_en_reg && ev_nack;
  end

  // register file flops
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wait_reg <= 1'h1;
      rdata_reg <= 32'h0000_0000;
      go_reg <= 1'h0;
      own_reg <= OWN_ADDR_RESET;
      thr_reg <= THR_RESET;
      dma_en_reg <= 1'h0;
      dsz_reg <= 2'h0;
      raw_reg <= 3'h0;
      mask_reg <= 4'h0;
      irq_reg <= 1'h0;
      dma_reg <= '0;
    end else begin
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
      go_reg <= go_next;
      own_reg <= own_next;
      thr_reg <= thr_next;
      dma_en_reg <= dma_en_next;
      dsz_reg <= dsz_next;
      raw_reg <= raw_next;
      mask_reg <= mask_next;
      irq_reg <= irq_next;
      dma_reg <= dma_next;
    end
  end

  assign avs_readdata_o = rdata_reg;
  assign avs_waitrequest_o = wait_reg;
  assign scl_o = pin_lo_reg;
  assign sda_o = pin_lo_reg;
  assign scl_oe_o = scl_drv_reg;
  assign sda_oe_o = sda_drv_reg;
  assign irq_o = irq_reg;
  assign dma_req_o = dma_reg;
endmodule

`default_nettype wire

//--- verilog/i2ctx_pkg.sv
`default_nettype none

package i2ctx_pkg;
  // register byte offsets on the avalon slave
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_TFR = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_DMA = 8'h18;
  localparam logic [7:0] OFF_RAW = 8'h1c;
  localparam logic [7:0] OFF_MASK = 8'h20;
  // control register fields
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_ADDR_LSB = 8;
  localparam int CTRL_THR_LSB = 16;
  localparam logic [6:0] OWN_ADDR_RESET = 7'h55;
  localparam logic [3:0] THR_RESET = 4'h2;
  // dma control fields
  localparam int DMA_EN_BIT = 0;
  localparam int DMA_SZ_LSB = 1;
  // interrupt flag positions, shared by raw flags and mask
  localparam int IRQ_REQ = 0;
  localparam int IRQ_EMPTY = 1;
  localparam int IRQ_DONE = 2;
  localparam int IRQ_NEAR = 3;
  localparam int IRQ_W = 4;
  // status register fields and codes
  localparam int STAT_OP_LSB = 0;
  localparam int STAT_ST_LSB = 2;
  localparam int STAT_LVL_LSB = 8;
  localparam logic [1:0] OP_MW = 2'h0;
  localparam logic [1:0] OP_RFS = 2'h3;
  localparam logic [1:0] ST_NOP = 2'h0;
  localparam logic [1:0] ST_ON = 2'h1;
  localparam logic [1:0] ST_OK = 2'h2;
  localparam logic [1:0] ST_ABORT = 2'h3;
  // transmit queue geometry
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW = 4;
  localparam int LVL_W = 5;
  // master-mode bus phase timing
  localparam int CLK_NS = 100;
  localparam int PHASE_NS = 400;
  localparam int PHASE_CYC = (PHASE_NS + CLK_NS - 1) / CLK_NS;

  // engine states, one-hot
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_MSTART = 9'h002,
    ST_MBIT = 9'h004,
    ST_MACK = 9'h008,
    ST_MSTOP = 9'h010,
    ST_SADDR = 9'h020,
    ST_SAACK = 9'h040,
    ST_SLOAD = 9'h080,
    ST_SBIT = 9'h100
  } i2ctx_state_e;

  // one avalon request as seen by the slave
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } i2ctx_bus_s;

  // dma request lines towards the dma engine
  typedef struct packed {
    logic single;
    logic burst;
    logic last;
  } i2ctx_dma_s;

  // burst length in bytes from the 2-bit size code
  function automatic logic [LVL_W-1:0] i2ctx_burst_len(input logic [1:0] sz);
    unique case (sz)
      2'h0: i2ctx_burst_len = 5'h01;
      2'h1: i2ctx_burst_len = 5'h04;
      2'h2: i2ctx_burst_len = 5'h08;
      default: i2ctx_burst_len = 5'h10;
    endcase
  endfunction
endpackage

`default_nettype wire

//--- verilog/i2ctx_fifo.sv
`default_nettype none

// byte queue with synchronous flush; push when full and pop when empty are ignored
module i2ctx_fifo
  import i2ctx_pkg::*;
(
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic push_i,
  input wire logic [7:0] data_i,
  input wire logic pop_i,
  input wire logic flush_i,
  output logic [7:0] head_o,
  output logic [LVL_W-1:0] level_o,
  output logic empty_o
);
  logic [7:0] mem_reg [FIFO_DEPTH]; // byte storage
  logic [FIFO_AW-1:0] wp_reg, wp_next; // write pointer
  logic [FIFO_AW-1:0] rp_reg, rp_next; // read pointer
  logic [LVL_W-1:0] cnt_reg, cnt_next; // fill level
  logic do_push; // accepted push
  logic do_pop; // accepted pop

  // pointer and level arithmetic; flush wins over both
  always_comb begin
    do_push = push_i && (cnt_reg != LVL_W'(FIFO_DEPTH)) && !flush_i;
    do_pop = pop_i && (cnt_reg != '0) && !flush_i;
    wp_next = do_push ? wp_reg + 4'h1 : wp_reg;
    rp_next = do_pop ? rp_reg + 4'h1 : rp_reg;
    cnt_next = cnt_reg + LVL_W'(do_push) - LVL_W'(do_pop);
    if (flush_i) begin
      wp_next = '0;
      rp_next = '0;
      cnt_next = '0;
    end
  end

  // pointer registers
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
    end
  end

  // storage write, no reset needed on data
  always_ff @(posedge mclk_i) begin
    if (do_push) begin
      mem_reg[wp_reg] <= data_i;
    end
  end

  assign head_o = mem_reg[rp_reg];
  assign level_o = cnt_reg;
  assign empty_o = (cnt_reg == '0);
endmodule

`default_nettype wire

//--- tb/i2ctx_chk.sv
`default_nettype none
// port-level checks beside the transmit feed
module i2ctx_chk
  import i2ctx_pkg::*;
(
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic scl_o,
  input wire logic sda_o,
  input wire i2ctx_dma_s dma_req_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);
  // a request still waiting for its answer
  sequence s_req;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  // one low cycle of waitrequest, then high again
  sequence s_ack;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  AST_ACK_ONE: assert property (s_req |=> s_ack)
    else $error("waitrequest answer not one cycle");
  AST_REST_HIGH: assert property (!(avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> avs_waitrequest_o)
    else $error("waitrequest dropped with no request");
  AST_TFR_RD0: assert property (avs_read_i && avs_waitrequest_o
    && avs_address_i == OFF_TFR |=> avs_readdata_o == 32'h0)
    else $error("transmit register read not zero");
  AST_SCL_OD: assert property (scl_o == 1'h0)
    else $error("clock line driven high");
  AST_SDA_OD: assert property (sda_o == 1'h0)
    else $error("data line driven high");
  AST_DMA_ONE: assert property (!(dma_req_o.single && dma_req_o.burst))
    else $error("single and burst together");
  AST_LAST_PULSE: assert property ($rose(dma_req_o.last) |=> !dma_req_o.last)
    else $error("dummy request longer than one cycle");
  AST_LAST_STOP: assert property (dma_req_o.last
    |-> ##[1:2] !(dma_req_o.single || dma_req_o.burst))
    else $error("dma requests go on after the end");
endmodule
`default_nettype wire

//--- tb/i2ctx_bus_model.sv
`default_nettype none
// external two-wire party: master of slave reads, slave of master writes
module i2ctx_bus_model (
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_oe_o,
  output logic sda_oe_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // released at rest, the pull-ups hold both lines high
  initial begin
    scl_oe_o = 1'h0;
    sda_oe_o = 1'h0;
  end
  // data falls while clock high, off the controller clock grid
  task automatic start();
    #37;
    sda_oe_o = 1'h1;
    #400;
    scl_oe_o = 1'h1;
  endtask
  // drive one bit, clock it, waiting out any stretch
  task automatic put(input logic v);
    #100;
    sda_oe_o = !v;
    #300;
    scl_oe_o = 1'h0;
    wait (scl_i === 1'h1);
    #400;
    scl_oe_o = 1'h1;
  endtask
  // release data, clock one bit in
  task automatic get(output logic v);
    #100;
    sda_oe_o = 1'h0;
    #300;
    scl_oe_o = 1'h0;
    wait (scl_i === 1'h1);
    #200;
    v = sda_i;
    #200;
    scl_oe_o = 1'h1;
  endtask
  // data rises while clock high
  task automatic stop();
    #100;
    sda_oe_o = 1'h1;
    #300;
    scl_oe_o = 1'h0;
    wait (scl_i === 1'h1);
    #400;
    sda_oe_o = 1'h0;
  endtask
  // slave of a master write: eight bits, then acknowledge
  task automatic rx(output logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      @(posedge scl_i);
      v[i] = sda_i;
    end
    @(negedge scl_i);
    #100;
    sda_oe_o = 1'h1;
    @(negedge scl_i);
    #100;
    sda_oe_o = 1'h0;
  endtask
endmodule
`default_nettype wire

//--- tb/tb.sv
`default_nettype none
// self-checking bench: registers, slave read, master write
module tb
  import i2ctx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i, resetn_i, avs_read_i, avs_write_i, b, last_seen;
  logic [7:0] avs_address_i, d0, d1, b0, b1, ab;
  logic [31:0] avs_writedata_i, avs_readdata_o, rdata, lfsr;
  logic avs_waitrequest_o, scl_o, sda_o, scl_oe_o, sda_oe_o, irq_o, m_scl, m_sda;
  i2ctx_dma_s dma_req_o;
  int num_errors, checked, cyc;
  // open-drain wires: low when any party pulls
  wire scl_w = ~(scl_oe_o | m_scl);
  wire sda_w = ~(sda_oe_o | m_sda);
  i2ctx_feed DUT (.mclk_i(mclk_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_byteenable_i(4'hf),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .scl_i(scl_w), .scl_o(scl_o),
    .scl_oe_o(scl_oe_o), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .irq_o(irq_o), .dma_req_o(dma_req_o));
  i2ctx_bus_model m (.scl_i(scl_w), .sda_i(sda_w), .scl_oe_o(m_scl), .sda_oe_o(m_sda));
  // next pseudo-random value
  function automatic logic [7:0] nxt();
    lfsr = {1'h0, lfsr[31:1]} ^ (lfsr[0] ? 32'h8020_0003 : 32'h0);
    return lfsr[7:0];
  endfunction
  // expected status word
  function automatic logic [31:0] stat(input logic [1:0] op, st, input logic [4:0] lvl);
    return {19'h0, lvl, 4'h0, st, op};
  endfunction
  // one avalon transfer; read data lands in rdata
  task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    // hold until a rising edge sees waitrequest low; read data is taken there too
    @(posedge mclk_i);
    while (avs_waitrequest_o !== 1'h0) @(posedge mclk_i);
    rdata = avs_readdata_o;
    avs_write_i <= 1'h0;
    avs_read_i <= 1'h0;
  endtask
  // compare and count
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  // verdict and end of run
  task automatic test_done();
    if (num_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    mclk_i = 1'h0;
    forever #50 mclk_i = ~mclk_i;
  end
  // cycle ceiling and dummy request capture
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (dma_req_o.last === 1'h1) last_seen <= 1'h1;
    if (cyc == 40000) begin
      num_errors++;
      test_done();
    end
  end
  initial begin
    lfsr = 32'h8491;
    {resetn_i, avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = '0;
    {num_errors, checked, cyc, last_seen} = '0;
    ab = {OWN_ADDR_RESET, 1'h1};
    repeat (16) @(posedge mclk_i);
    resetn_i <= 1'h1;
    rw(1'h0, OFF_STATUS, 32'h0);
    chk("status", stat(OP_MW, ST_NOP, 5'h0), rdata);
    rw(1'h0, OFF_TFR, 32'h0);
    chk("tfr", 32'h0, rdata);
    rw(1'h0, 8'h24, 32'h0);
    chk("unmapped", 32'h0, rdata);
    chk("irq", 32'h0, {31'h0, irq_o});
    rw(1'h1, OFF_MASK, 32'h8);
    repeat (2) @(posedge mclk_i);
    chk("irq", 32'h1, {31'h0, irq_o});
    for (int i = 1; i <= 3; i++) begin
      rw(1'h1, OFF_TFR, {nxt(), nxt(), nxt(), nxt()});
      rw(1'h0, OFF_RAW, 32'h0);
      chk("near", {31'h0, i <= 2}, {31'h0, rdata[IRQ_NEAR]});
    end
    rw(1'h0, OFF_STATUS, 32'h0);
    chk("level", stat(OP_MW, ST_NOP, 5'h3), rdata);
    rw(1'h1, OFF_MASK, 32'h1);
    rw(1'h1, OFF_DMA, 32'h7);
    m.start();
    for (int i = 7; i >= 0; i--) m.put(ab[i]);
    m.get(b);
    chk("addr ack", 32'h0, {31'h0, b});
    repeat (8) @(posedge mclk_i);
    chk("stretch", 32'h1, {31'h0, scl_oe_o});
    chk("dma", 32'h2, {29'h0, dma_req_o});
    chk("irq", 32'h1, {31'h0, irq_o});
    rw(1'h0, OFF_RAW, 32'h0);
    chk("flags", 32'hb, rdata);
    rw(1'h0, OFF_STATUS, 32'h0);
    chk("flushed", stat(OP_RFS, ST_ON, 5'h0), rdata);
    rw(1'h1, OFF_RAW, 32'h3);
    repeat (2) @(posedge mclk_i);
    chk("irq", 32'h0, {31'h0, irq_o});
    b0 = nxt();
    b1 = nxt();
    fork
      begin
        for (int i = 0; i < 8; i++) m.get(d0[i]);
        m.put(1'h0);
        for (int i = 0; i < 8; i++) m.get(d1[i]);
        m.put(1'h1);
        m.stop();
      end
      begin
        rw(1'h1, OFF_TFR, {24'h0, b0});
        rw(1'h1, OFF_TFR, {24'h0, b1});
      end
    join
    chk("byte0", {24'h0, b0}, {24'h0, d0});
    chk("byte1", {24'h0, b1}, {24'h0, d1});
    rw(1'h0, OFF_RAW, 32'h0);
    chk("done", 32'hc, rdata);
    rw(1'h0, OFF_STATUS, 32'h0);
    chk("read ok", stat(OP_RFS, ST_OK, 5'h0), rdata);
    chk("last", 32'h1, {31'h0, last_seen});
    rw(1'h1, OFF_DMA, 32'h0);
    rw(1'h1, OFF_CTRL, {12'h0, THR_RESET, 1'h0, OWN_ADDR_RESET, 8'h1});
    repeat (40) @(posedge mclk_i);
    chk("idle", 32'h0, {30'h0, scl_oe_o, sda_oe_o});
    b0 = nxt();
    fork
      m.rx(d0);
      rw(1'h1, OFF_TFR, {24'h0, b0});
    join
    repeat (60) @(posedge mclk_i);
    chk("mw byte", {24'h0, b0}, {24'h0, d0});
    rw(1'h0, OFF_STATUS, 32'h0);
    chk("mw ok", stat(OP_MW, ST_OK, 5'h0), rdata);
    test_done();
  end
endmodule
bind i2ctx_feed i2ctx_chk u_chk (.mclk_i(mclk_i), .resetn_i(resetn_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .scl_o(scl_o), .sda_o(sda_o), .dma_req_o(dma_req_o));
`default_nettype wire
